/* File: rtl/fdcr_regs.sv */
// Floppy drive control and status register bank with Wishbone slave
// What this block does
// - AT mode: pin status read returns nothing; bus reads zero instead.
// - Enhanced mode: bits 7,6 read one; bit2 write gate; bit1 zero; bit0 motor 0.
// - Enhanced mode: bit 3 toggles on each inactive read data edge.
// - Enhanced mode: bit 4 toggles on each inactive write data edge.
// - Motor status low after hardware reset, kept over soft reset.
// - Enhanced mode: bit 5 mirrors drive number bit 0.
// - Alternate mode: bit 2 latches rising write gate, cleared by input read.
// - Alternate mode: bits 3,4 latch inactive data edges, cleared likewise.
// - Alternate write data latch ignores write gate.
// - Alternate mode: bit5 select0 low-active; bits 6,1,0 read one.
// - Drive control writable anytime; soft reset keeps it; hard reset zeroes.
// - Drive control bits 1:0 binary drive number, at most one drive selected.
// - Bit 2 zero holds controller reset until one written.
// - AT and alternate modes: bit 3 enables DMA and interrupts.
// - Enhanced mode: DMA and interrupts always enabled.
// - Bit 4 drives motor 0 active, bit 5 motor 1; bits 6-7 unsupported motors.
// - Normal decode: drive 00 with bit4 selects 0, 01 with bit5 selects 1.
// - Swapped decode exchanges selects and motor bits.
// - Tape select bits 1:0 encode tape drive number.
// - Soft reset leaves tape register unchanged.
// - Normal floppy mode: tape register reads zero in bits 7:2.
// - Enhanced floppy mode 2: type id, boot drive, tape select fields.
// - Boot drive field reads zero.
// - Drive type picks config pair by drive number.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
module fdcr_regs
    import fdcr_pkg::*;
(
    // Clock and reset
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    // Wishbone slave
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [11:0]     wb_adr_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [31:0]     wb_dat_i,
    output logic      [31:0]     wb_dat_o,
    output logic                 wb_ack_o,
    // Configuration
    input  wire fdcr_mode_t      mode_i,
    input  wire logic            swap_decode_i,
    input  wire logic            enhanced_floppy_mode_2_i,
    input  wire logic [7:0]      drive_type_cfg_i,
    // Drive interface
    input  wire fdcr_pins_t      pins_i,
    input  wire logic            write_gate_i,
    output fdcr_drive_out_t      drive_o,
    output logic                 dma_irq_enable_o,
    output logic                 soft_reset_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]      rd_s1;
        logic [1:0]      rd_s2;
        logic [1:0]      rd_d;
        logic            wg_d;
        logic [7:0]      ctrl;
        logic [1:0]      tape;
        logic            rd_tog;
        logic            wd_tog;
        logic            wg_lat;
        logic            rd_lat;
        logic            wd_lat;
        logic [31:0]     dat;
        logic            ack;
        fdcr_drive_out_t drv;
        logic            dma_en;
        logic            srst;
    } fdcr_state_t;

    fdcr_state_t state_reg;
    fdcr_state_t state_next;

    logic [9:0] idx;
    logic       req;
    logic       wr;
    logic       rd;
    logic       rd_fall;
    logic       wd_fall;
    logic       wg_rise;
    logic [7:0] pin_status;
    logic [7:0] tape_rd;
    logic [1:0] dtype;
    logic [7:0] rdata;
    logic [7:0] c;
    logic       sel0;
    logic       sel1;

    assign idx = wb_adr_i[11:2];
    assign req = wb_cyc_i && wb_stb_i && !state_reg.ack;
    assign wr  = req && wb_we_i && wb_sel_i[0];
    assign rd  = req && !wb_we_i;

    // ------------------------------------------------------------
    // Edge detection on synchronised pins
    // ------------------------------------------------------------
    // Inactive edge of an active-low data pulse is its rising edge
    assign rd_fall = state_reg.rd_s2[1] && !state_reg.rd_d[1];
    assign wd_fall = state_reg.rd_s2[0] && !state_reg.rd_d[0];
    // Write gate is our own-clock signal, no synchroniser needed
    assign wg_rise = write_gate_i && !state_reg.wg_d;

    always_comb begin
        dtype = drive_type_cfg_i[1:0];
        unique case (state_reg.ctrl[1:0])
            2'h0: dtype = drive_type_cfg_i[1:0];
            2'h1: dtype = drive_type_cfg_i[3:2];
            2'h2: dtype = drive_type_cfg_i[5:4];
            2'h3: dtype = drive_type_cfg_i[7:6];
        endcase
    end

    always_comb begin
        pin_status = 8'h00;
        unique case (mode_i)
            FDCR_MODE_ENH: begin
                pin_status = {2'h3, state_reg.ctrl[0],
                              state_reg.wd_tog, state_reg.rd_tog,
                              write_gate_i, 1'b0,
                              state_reg.ctrl[FDCR_DC_MOT0]};
            end
            FDCR_MODE_ALT: begin
                // Unsupported select lines stay inactive high
                pin_status = {1'b1, 1'b1, state_reg.drv.drive0_select_n,
                              state_reg.wd_lat, state_reg.rd_lat,
                              state_reg.wg_lat, 2'h3};
            end
            default: pin_status = 8'h00;
        endcase
    end

    always_comb begin
        if (enhanced_floppy_mode_2_i) begin
            tape_rd = {2'h0, dtype, 2'h0, state_reg.tape};
        end else begin
            tape_rd = {6'h00, state_reg.tape};
        end
    end

    always_comb begin
        rdata = 8'h00;
        if (idx == FDCR_PIN_STATUS_IDX) begin
            rdata = pin_status;
        end else if (idx == FDCR_DRIVE_CTRL_IDX) begin
            rdata = state_reg.ctrl;
        end else if (idx == FDCR_TAPE_ASSIGN_IDX) begin
            rdata = tape_rd;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        c = state_reg.ctrl;
        state_next.rd_s1 = {pins_i.rdata_n, pins_i.wdata_n};
        state_next.rd_s2 = state_reg.rd_s1;
        state_next.rd_d  = state_reg.rd_s2;
        state_next.wg_d  = write_gate_i;
        state_next.ack   = req;
        state_next.dat   = {24'h000000, rdata};
        if (wr && idx == FDCR_DRIVE_CTRL_IDX) begin
            c = wb_dat_i[7:0];
        end
        if (wr && idx == FDCR_TAPE_ASSIGN_IDX) begin
            state_next.tape = wb_dat_i[1:0];
        end
        state_next.ctrl = c;
        if (rd_fall) begin
            state_next.rd_tog = !state_reg.rd_tog;
        end
        if (wd_fall) begin
            state_next.wd_tog = !state_reg.wd_tog;
        end
        // Latches cleared by input register read; set wins over clear
        if (rd && idx == FDCR_DIGITAL_IN_IDX) begin
            state_next.wg_lat = 1'b0;
            state_next.rd_lat = 1'b0;
            state_next.wd_lat = 1'b0;
        end
        if (wg_rise) begin
            state_next.wg_lat = 1'b1;
        end
        if (rd_fall) begin
            state_next.rd_lat = 1'b1;
        end
        if (wd_fall) begin
            state_next.wd_lat = 1'b1;
        end
        // Binary drive number gives at most one select
        sel0 = 1'b0;
        sel1 = 1'b0;
        if (c[1:0] == 2'h0 && c[FDCR_DC_MOT0]) begin
            sel0 = 1'b1;
        end else if (c[1:0] == 2'h1 && c[FDCR_DC_MOT1]) begin
            sel1 = 1'b1;
        end
        if (swap_decode_i) begin
            state_next.drv.drive0_select_n = !sel1;
            state_next.drv.drive1_select_n = !sel0;
            state_next.drv.motor0_n = !c[FDCR_DC_MOT1];
            state_next.drv.motor1_n = !c[FDCR_DC_MOT0];
        end else begin
            state_next.drv.drive0_select_n = !sel0;
            state_next.drv.drive1_select_n = !sel1;
            state_next.drv.motor0_n = !c[FDCR_DC_MOT0];
            state_next.drv.motor1_n = !c[FDCR_DC_MOT1];
        end
        state_next.dma_en = (mode_i == FDCR_MODE_ENH)
                          || c[FDCR_DC_DMA_EN];
        // Held for as long as the bit stays zero; 50 ns per cycle
        state_next.srst = !c[FDCR_DC_RESET_N];
    end

    // ------------------------------------------------------------
    // Registers; soft reset is an output only, nothing here obeys it
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg        <= '0;
            state_reg.ctrl   <= FDCR_DC_RESET_VAL;
            state_reg.tape   <= FDCR_TAPE_RESET_VAL;
            state_reg.rd_s1  <= 2'h3;
            state_reg.rd_s2  <= 2'h3;
            state_reg.rd_d   <= 2'h3;
            state_reg.drv    <= 4'hF;
            state_reg.srst   <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign wb_dat_o         = state_reg.dat;
    assign wb_ack_o         = state_reg.ack;
    assign drive_o          = state_reg.drv;
    assign dma_irq_enable_o = state_reg.dma_en;
    assign soft_reset_o     = state_reg.srst;

endmodule

/* File: rtl/fdcr_pkg.sv */
// Package: register map, field positions, modes and carrier types
package fdcr_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [9:0] FDCR_PIN_STATUS_IDX  = 10'h3F1;
    localparam logic [9:0] FDCR_DRIVE_CTRL_IDX  = 10'h3F2;
    localparam logic [9:0] FDCR_TAPE_ASSIGN_IDX = 10'h3F3;
    localparam logic [9:0] FDCR_DIGITAL_IN_IDX  = 10'h3F7;

    // ------------------------------------------------------------
    // Drive control fields
    // ------------------------------------------------------------
    localparam int FDCR_DC_DRV_LO    = 0;
    localparam int FDCR_DC_RESET_N   = 2;
    localparam int FDCR_DC_DMA_EN    = 3;
    localparam int FDCR_DC_MOT0      = 4;
    localparam int FDCR_DC_MOT1      = 5;
    localparam logic [7:0] FDCR_DC_RESET_VAL = 8'h00;
    localparam logic [1:0] FDCR_TAPE_RESET_VAL = 2'h0;
    localparam logic [7:0] FDCR_DRVTYPE_RESET_VAL = 8'h00;

    // ------------------------------------------------------------
    // Modes and carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FDCR_MODE_AT,
        FDCR_MODE_ENH,
        FDCR_MODE_ALT
    } fdcr_mode_t;

    typedef struct packed {
        logic rdata_n;
        logic wdata_n;
    } fdcr_pins_t;

    typedef struct packed {
        logic drive0_select_n;
        logic drive1_select_n;
        logic motor0_n;
        logic motor1_n;
    } fdcr_drive_out_t;

endpackage

/* File: testbench/fdcr_regs_monitor.sv */
// Assertion checker for the floppy control and status register bank
`timescale 1ns/1ps
module fdcr_regs_monitor
    import fdcr_pkg::*;
(
    // Clock, reset and bus
    input wire logic            clk_i,
    input wire logic            rst_i,
    input wire logic            wb_cyc_i,
    input wire logic            wb_stb_i,
    input wire logic            wb_we_i,
    input wire logic [11:0]     wb_adr_i,
    input wire logic [3:0]      wb_sel_i,
    input wire logic [31:0]     wb_dat_i,
    input wire logic [31:0]     wb_dat_o,
    input wire logic            wb_ack_o,
    // Configuration and drive side
    input wire fdcr_mode_t      mode_i,
    input wire logic            swap_decode_i,
    input wire logic            enhanced_floppy_mode_2_i,
    input wire fdcr_drive_out_t drive_o,
    input wire logic            dma_irq_enable_o,
    input wire logic            soft_reset_o
);
    // ----------------------------------------
    // Request decode
    // ----------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       req;
    logic       rd_ack;
    logic       wr_ctrl;
    logic [9:0] idx;
    assign idx = wb_adr_i[11:2];
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd_ack = wb_ack_o && !wb_we_i;
    assign wr_ctrl = req && wb_we_i && wb_sel_i[0]
                     && idx == FDCR_DRIVE_CTRL_IDX;
    ack_answer_a: assert property (req |=> wb_ack_o)
        else $error("no ack one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    at_silent_a: assert property (rd_ack && idx == FDCR_PIN_STATUS_IDX
        && mode_i == FDCR_MODE_AT |-> wb_dat_o == 32'h0)
        else $error("pin status not silent in AT mode");
    enh_fixed_a: assert property (rd_ack && idx == FDCR_PIN_STATUS_IDX
        && mode_i == FDCR_MODE_ENH |-> wb_dat_o[7:6] == 2'h3)
        else $error("pin status top bits not one");
    tape_zero_a: assert property (rd_ack && idx == FDCR_TAPE_ASSIGN_IDX
        && !enhanced_floppy_mode_2_i |-> wb_dat_o[7:2] == 6'h0)
        else $error("tape upper bits not zero");
    boot_zero_a: assert property (rd_ack && idx == FDCR_TAPE_ASSIGN_IDX
        && enhanced_floppy_mode_2_i |-> wb_dat_o[3:2] == 2'h0)
        else $error("boot drive field not zero");
    soft_rst_a: assert property (wr_ctrl |->
        ##2 soft_reset_o == !$past(wb_dat_i[2], 2))
        else $error("soft reset does not follow control");
    motor_map_a: assert property (wr_ctrl && !swap_decode_i |->
        ##2 drive_o.motor0_n == !$past(wb_dat_i[4], 2))
        else $error("motor output does not follow control");
    dma_enh_a: assert property (!$past(rst_i)
        && $past(mode_i) == FDCR_MODE_ENH |-> dma_irq_enable_o)
        else $error("dma not enabled in enhanced mode");
    cover property (wr_ctrl && !wb_dat_i[2]);
    cover property (wr_ctrl && swap_decode_i);
    cover property (rd_ack && mode_i == FDCR_MODE_ALT);
endmodule

bind fdcr_regs fdcr_regs_monitor mon_u (.*);

/* File: testbench/fdcr_drive_model.sv */
// Drive-side model: read and write data lines, idle high
`timescale 1ns/1ps
module fdcr_drive_model
    import fdcr_pkg::*;
(
    // Clock and pulse requests from the bench
    input  wire logic       clk_i,
    input  wire logic [1:0] pulse_i,
    // Data lines toward the controller
    output fdcr_pins_t      pins_o
);
    // Pulses leave from an edge so widths are whole cycles
    initial pins_o = 2'h3;
    always @(posedge clk_i) pins_o <= ~pulse_i;
endmodule

/* File: testbench/tb_fdcr_regs.sv */
// Self-checking bench for the floppy control and status register bank
`timescale 1ns/1ps
module tb_fdcr_regs
    import fdcr_pkg::*;
;
    logic            clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic            swap_i, fm2_i, wg_i, dma_o, srst_o;
    logic            rt, wt, rl, wl, gl, wg;
    logic [11:0]     wb_adr_i;
    logic [3:0]      wb_sel_i, s;
    logic [31:0]     wb_dat_i, wb_dat_o;
    logic [7:0]      cfg_i, m_ctrl, d, q, ty;
    logic [1:0]      m_tape, pulse;
    fdcr_mode_t      mode_i;
    fdcr_pins_t      pins;
    fdcr_drive_out_t drive_o;
    int              err_count, cmp_count;

    fdcr_regs dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .mode_i(mode_i), .swap_decode_i(swap_i),
        .enhanced_floppy_mode_2_i(fm2_i), .drive_type_cfg_i(cfg_i),
        .pins_i(pins), .write_gate_i(wg_i), .drive_o(drive_o),
        .dma_irq_enable_o(dma_o), .soft_reset_o(srst_o));
    fdcr_drive_model drv_u (.clk_i(clk_i), .pulse_i(pulse), .pins_o(pins));

    initial begin
        clk_i = 1'h0;
        forever #25 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // Reference model and bus tasks
    // ----------------------------------------
    function automatic fdcr_drive_out_t dec();
        logic s0, s1;
        s0 = m_ctrl[1:0] == 2'h0 && m_ctrl[4];
        s1 = m_ctrl[1:0] == 2'h1 && m_ctrl[5];
        return swap_i ? {~s1, ~s0, ~m_ctrl[5], ~m_ctrl[4]}
                      : {~s0, ~s1, ~m_ctrl[4], ~m_ctrl[5]};
    endfunction
    function automatic logic [7:0] pin_exp();
        fdcr_drive_out_t o;
        o = dec();
        if (mode_i == FDCR_MODE_ENH)
            return {2'h3, m_ctrl[0], wt, rt, wg, 1'h0, m_ctrl[4]};
        if (mode_i == FDCR_MODE_ALT)
            return {2'h1, o.drive0_select_n, wl, rl, gl, 2'h3};
        return 8'h00;
    endfunction
    task automatic chk(string n, logic [31:0] sn, logic [31:0] e);
        cmp_count++;
        if (sn !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, sn);
        end
    endtask
    task automatic bus(logic w, logic [9:0] a, logic [7:0] v, logic [3:0] b);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= {a, 2'h0};
        wb_dat_i <= {24'h0, v};
        wb_sel_i <= b;
        @(posedge clk_i);
        // Only the watchdog ends a wait for the answer
        while (wb_ack_o !== 1'h1) begin
            @(posedge clk_i);
        end
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        @(posedge clk_i);
    endtask
    task automatic rd(logic [9:0] a, logic [7:0] e, logic [7:0] m, string n);
        bus(1'h0, a, 8'h00, 4'hF);
        chk(n, q & m, e & m);
    endtask
    task automatic pls(logic [1:0] p);
        pulse <= p;
        repeat (1 + $urandom % 3) @(posedge clk_i);
        pulse <= 2'h0;
        repeat (8) @(posedge clk_i);
        // Toggles run in every mode; only enhanced mode shows them
        {rt, wt} = {rt, wt} ^ p;
        {rl, wl} = {rl, wl} | p;
    endtask
    task automatic stop_test();
        if (err_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        stop_test();
    end

    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, swap_i, fm2_i, wg_i} = 7'h40;
        {wb_adr_i, wb_sel_i, wb_dat_i, cfg_i, pulse} = '0;
        mode_i = FDCR_MODE_AT;
        {m_ctrl, m_tape, rt, wt, rl, wl, gl, wg, err_count, cmp_count} = '0;
        void'($urandom(32'hAAE2CA39));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        chk("drive out", drive_o, 4'hF);
        for (int k = 0; k < 3; k++) begin
            mode_i <= fdcr_mode_t'(k);
            @(posedge clk_i);
            bus(1'h0, FDCR_DIGITAL_IN_IDX, 8'h00, 4'hF);
            {rl, wl, gl} = 3'h0;
            repeat (12) begin
                swap_i <= $urandom;
                fm2_i <= $urandom;
                cfg_i <= $urandom;
                d = $urandom;
                s = $urandom;
                bus(1'h1, FDCR_DRIVE_CTRL_IDX, d, s);
                if (s[0]) m_ctrl = d;
                chk("drive out", drive_o, dec());
                chk("dma", dma_o, mode_i == FDCR_MODE_ENH || m_ctrl[3]);
                chk("soft reset", srst_o, !m_ctrl[2]);
                rd(FDCR_DRIVE_CTRL_IDX, m_ctrl, 8'hFF, "control");
                d = $urandom;
                bus(1'h1, FDCR_TAPE_ASSIGN_IDX, d, 4'hF);
                m_tape = d[1:0];
                ty = cfg_i >> {m_ctrl[1:0], 1'h0};
                d = fm2_i ? {2'h0, ty[1:0], 2'h0, m_tape} : {6'h0, m_tape};
                rd(FDCR_TAPE_ASSIGN_IDX, d, 8'h3F, "tape");
                wg = $urandom;
                gl = gl | (wg & !wg_i);
                wg_i <= wg;
                if (mode_i != FDCR_MODE_AT) pls($urandom);
                d = mode_i == FDCR_MODE_ALT ? 8'h7F : 8'hFF;
                rd(FDCR_PIN_STATUS_IDX, pin_exp(), d, "pin");
                rd(FDCR_DIGITAL_IN_IDX, 8'h00, 8'hFF, "digital in");
                {rl, wl, gl} = 3'h0;
                rd(10'h3F0, 8'h00, 8'hFF, "unmapped");
            end
        end
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        mode_i <= FDCR_MODE_ENH;
        fm2_i <= 1'h0;
        wg_i <= 1'h0;
        @(posedge clk_i);
        rd(FDCR_PIN_STATUS_IDX, 8'hC0, 8'hFF, "pin");
        rd(FDCR_DRIVE_CTRL_IDX, 8'h00, 8'hFF, "control");
        rd(FDCR_TAPE_ASSIGN_IDX, 8'h00, 8'hFF, "tape");
        stop_test();
    end
endmodule
